// *** verilog/abw_params.svh ***
`ifndef ABW_PARAMS_SVH
`define ABW_PARAMS_SVH

// clock period in ps (200 MHz)
`define ABW_CLK_PS        5000
// strobe high recovery, ns
`define ABW_T_HIGH_NS     2
// minimum cycle, ns
`define ABW_T_CYCLE_NS    35
// minimum write pulse, ns
`define ABW_T_PULSE_NS    15
// data valid to end of write, ns
`define ABW_T_DATA_NS     10
// write high to memory may drive, ns
`define ABW_T_RECOV_NS    3
// startup time after power up, ms
`define ABW_T_START_MS    2
// cycle counts, least times rounded up
`define ABW_CYC_HIGH      ((`ABW_T_HIGH_NS * 1000 + `ABW_CLK_PS - 1) / `ABW_CLK_PS)
`define ABW_CYC_CYCLE     ((`ABW_T_CYCLE_NS * 1000 + `ABW_CLK_PS - 1) / `ABW_CLK_PS)
`define ABW_CYC_PULSE     ((`ABW_T_PULSE_NS * 1000 + `ABW_CLK_PS - 1) / `ABW_CLK_PS)
`define ABW_CYC_START     ((`ABW_T_START_MS * 1000000000 + `ABW_CLK_PS - 1) / `ABW_CLK_PS)
// counter width
`define ABW_CNT_W         20

`endif

// *** verilog/abw_pkg.sv ***
package abw_pkg;

  // write request from user side
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
    logic        by_cs;
  } abw_req_t;

  // strobes toward the memory, active low
  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic oe_n;
  } abw_strobe_t;

  typedef enum logic [2:0] {
    ABW_ST_START = 3'b000,
    ABW_ST_IDLE  = 3'b001,
    ABW_ST_SETUP = 3'b010,
    ABW_ST_PULSE = 3'b011,
    ABW_ST_HOLD  = 3'b100
  } abw_state_t;

endpackage : abw_pkg

// *** verilog/abw_timer.sv ***
`timescale 1ns/100ps
// loadable down counter, done while zero
module abw_timer #(
  parameter int W = 20
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  output logic              o_done
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  // reload wins over counting
  always_comb begin
    next_cnt = cnt;
    if (i_load) begin
      next_cnt = i_value;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign o_done = (cnt == '0);

endmodule : abw_timer

// *** verilog/abw_host.sv ***
`timescale 1ns/100ps
`include "abw_params.svh"
module abw_host
  import abw_pkg::*;
#(
  parameter int unsigned START_CYC = `ABW_CYC_START,
  parameter int unsigned PULSE_CYC = `ABW_CYC_PULSE,
  parameter int unsigned CYCLE_CYC = `ABW_CYC_CYCLE,
  parameter int unsigned HIGH_CYC  = `ABW_CYC_HIGH
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_req_valid,
  input  wire abw_req_t    i_req,
  output logic             o_req_ready,
  output logic             o_done,
  output abw_strobe_t      o_strobe,
  output logic [14:0]      o_addr,
  output logic [7:0]       o_dq_out,
  output logic             o_dq_oe
);

  localparam int CW = `ABW_CNT_W;

  abw_state_t  state;
  abw_state_t  next_state;
  abw_strobe_t next_strobe;
  logic [14:0] next_addr;
  logic [7:0]  next_dq_out;
  logic        next_dq_oe;
  logic        next_ready;
  logic        next_done;
  logic        by_cs;
  logic        next_by_cs;
  logic        load_pulse;
  logic [CW-1:0] pulse_val;
  logic        pulse_done;
  logic        load_cyc;
  logic        cyc_done;
  logic        started;
  logic        next_started;
  logic        start_load;
  logic        start_done;
  logic        take;

  // phase timer: write pulse width, then high recovery
  abw_timer #(.W(CW)) u_phase (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_load  (load_pulse),
    .i_value (pulse_val),
    .o_done  (pulse_done)
  );

  // cycle timer: spacing of chip-select falls and address stability
  abw_timer #(.W(CW)) u_cycle (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_load  (load_cyc),
    .i_value (CW'(CYCLE_CYC)),
    .o_done  (cyc_done)
  );

  // a request is taken only on an edge where ready already stands
  assign take = i_req_valid && o_req_ready;

  // write sequencer; oe_n is never lowered, so the memory never drives
  always_comb begin
    // hold strobes, address and data unless a phase below moves them; ready and done default low
    next_state  = state;
    next_strobe = o_strobe;
    next_addr   = o_addr;
    next_dq_out = o_dq_out;
    next_dq_oe  = o_dq_oe;
    next_ready  = 1'b0;
    next_done   = 1'b0;
    next_by_cs  = by_cs;
    load_pulse  = 1'b0;
    pulse_val   = CW'(PULSE_CYC);
    load_cyc    = 1'b0;

    unique case (state)
      ABW_ST_START: begin
        // strobes stay high during startup
        if (started && start_done) begin
          next_state = ABW_ST_IDLE;
          next_ready = 1'b1;
        end
      end

      ABW_ST_IDLE: begin
        next_ready = 1'b1;
        if (take) begin
          // address and data settle one cycle before strobes fall
          next_addr   = i_req.addr;
          next_dq_out = i_req.data;
          next_dq_oe  = 1'b1; // oe_n high and we_n due low
          next_by_cs  = i_req.by_cs;
          next_ready  = 1'b0;
          next_state  = ABW_ST_SETUP;
        end
      end

      ABW_ST_SETUP: begin
        // hold off until last cycle expired
        if (cyc_done) begin
          next_strobe.cs_n = 1'b0; // overlap opens write
          next_strobe.we_n = 1'b0;
          load_pulse = 1'b1;
          load_cyc   = 1'b1;
          next_state = ABW_ST_PULSE;
        end
      end

      ABW_ST_PULSE: begin
        // full width pulse before the ending strobe rises
        if (pulse_done) begin
          if (by_cs) begin
            next_strobe.cs_n = 1'b1; // select ends it
          end else begin
            next_strobe.we_n = 1'b1;
          end
          load_pulse = 1'b1;
          pulse_val  = CW'(HIGH_CYC);
          next_state = ABW_ST_HOLD;
        end
      end

      ABW_ST_HOLD: begin
        // both strobes high, recovery kept
        next_strobe.cs_n = 1'b1;
        next_strobe.we_n = 1'b1;
        // address held until the cycle time ran out
        if (pulse_done && cyc_done) begin
          next_dq_oe = 1'b0;
          next_done  = 1'b1;
          next_ready = 1'b1;
          next_state = ABW_ST_IDLE;
        end
      end

      default: begin
        next_state = ABW_ST_IDLE;
      end
    endcase
  end

  // startup group: the first cycle after reset loads the long wait
  always_comb begin
    next_started = 1'b1;
    start_load   = !started;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      started <= 1'b0;
    end else begin
      started <= next_started;
    end
  end

  // long wait after reset; its idle zero is masked by started
  abw_timer #(.W(CW)) u_start (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_load  (start_load),
    .i_value (CW'(START_CYC)),
    .o_done  (start_done)
  );

  // state and handshake registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state       <= ABW_ST_START;
      o_req_ready <= 1'b0;
      o_done      <= 1'b0;
    end else begin
      state       <= next_state;
      o_req_ready <= next_ready;
      o_done      <= next_done;
    end
  end

  // strobe registers; all high in reset so nothing is written
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_strobe <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
    end else begin
      o_strobe <= next_strobe;
    end
  end

  // address and data registers, held for the whole cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_addr   <= 15'h0000;
      o_dq_out <= 8'h00;
      o_dq_oe  <= 1'b0;
      by_cs    <= 1'b0;
    end else begin
      o_addr   <= next_addr;
      o_dq_out <= next_dq_out;
      o_dq_oe  <= next_dq_oe;
      by_cs    <= next_by_cs;
    end
  end

endmodule : abw_host

// *** sim/abw_mem_model.sv ***
`timescale 1ns/100ps
// byte-wide memory seen from the host side
module abw_mem_model
  import abw_pkg::*;
(
  input wire abw_strobe_t i_strb,
  input wire logic [14:0] i_addr,
  inout wire logic [7:0]  io_dq
);
  logic [7:0] mem [0:32767];
  // store only while select and write strobe overlap
  always @* if (!i_strb.cs_n && !i_strb.we_n) mem[i_addr] = io_dq;
  // lanes driven for reads only, so a write never sees them driven
  assign io_dq = (!i_strb.cs_n && !i_strb.oe_n && i_strb.we_n) ?
                 mem[i_addr] : 8'hzz;
endmodule : abw_mem_model

// *** sim/abw_host_props.sv ***
`timescale 1ns/100ps
module abw_host_props
  import abw_pkg::*;
#(
  parameter int unsigned START_CYC = 20
) (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_req_valid,
  input wire abw_req_t    i_req,
  input wire logic        o_req_ready,
  input wire logic        o_done,
  input wire abw_strobe_t o_strobe,
  input wire logic [14:0] o_addr,
  input wire logic [7:0]  o_dq_out,
  input wire logic        o_dq_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic [19:0] up;
  // cycles since reset, saturating so it cannot wrap
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) up <= 20'h0;
    else if (up < START_CYC) up <= up + 20'h1;
  end
  AST_START:
    assert property (up < START_CYC |-> o_strobe.cs_n && o_strobe.we_n && !o_req_ready)
    else $error("access during startup");
  AST_OE_OFF:
    assert property (o_strobe.oe_n) else $error("output enable driven low");
  AST_WE_HIGH:
    assert property ($rose(o_strobe.we_n) |=> o_strobe.we_n) else $error("short we high");
  AST_CS_HIGH:
    assert property ($rose(o_strobe.cs_n) |=> o_strobe.cs_n) else $error("short cs high");
  AST_CS_SPACE:
    assert property ($fell(o_strobe.cs_n) |=> !$fell(o_strobe.cs_n) [*6])
    else $error("cs falls too close");
  AST_ADDR:
    assert property ($changed(o_addr) |=> $stable(o_addr) [*6]) else $error("short cycle");
  AST_WE_PULSE:
    assert property ($fell(o_strobe.we_n) |-> !o_strobe.we_n [*3]) else $error("short we");
  AST_CS_PULSE:
    assert property ($fell(o_strobe.cs_n) |-> !o_strobe.cs_n [*3]) else $error("short cs");
  AST_WINDOW:
    assert property (!o_strobe.cs_n && !o_strobe.we_n |-> o_dq_oe && $stable(o_dq_out))
    else $error("data not driven in window");
  AST_DONE:
    assert property (o_done |=> !o_done) else $error("done too long");
endmodule : abw_host_props
bind abw_host abw_host_props #(.START_CYC(START_CYC)) u_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_req_valid(i_req_valid), .i_req(i_req),
  .o_req_ready(o_req_ready), .o_done(o_done), .o_strobe(o_strobe),
  .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));

// *** sim/abw_host_test.sv ***
`timescale 1ns/100ps
module abw_host_test;
  import abw_pkg::*;
  logic        i_clk       = 1'b0;
  logic        i_rstn      = 1'b0;
  logic        i_req_valid = 1'b0;
  abw_req_t    i_req       = '0;
  logic        o_req_ready;
  logic        o_done;
  logic        o_dq_oe;
  abw_strobe_t o_strobe;
  logic [14:0] o_addr;
  logic [7:0]  o_dq_out;
  wire  [7:0]  dq;
  int          bad_count   = 0;
  int          checks      = 0;
  always #2.5 i_clk = ~i_clk;
  // host lanes released to z whenever its enable is low
  assign dq = o_dq_oe ? o_dq_out : 8'hzz;
  abw_host #(.START_CYC(20)) dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(o_req_ready), .o_done(o_done), .o_strobe(o_strobe),
    .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));
  abw_mem_model u_mem (.i_strb(o_strobe), .i_addr(o_addr), .io_dq(dq));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : cmp
  // one write: hold valid until taken, then wait for done, bounded
  task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic c);
    int n;
    int k;
    i_req_valid = 1'b1;
    i_req = '{a, d, c};
    n = 0;
    do begin @(posedge i_clk); n++; end while (o_req_ready !== 1'b1 && n < 300);
    #1 i_req_valid = 1'b0;
    k = n;
    do begin @(posedge i_clk); n++; end while (o_done !== 1'b1 && n < 300);
    #1;
    if (n >= 300) begin
      cmp(8'h00, 8'h01, "timeout");
      tally_and_finish();
    end
    // 35 ns at 5 ns per cycle is at least 7 cycles from take to done
    cmp({7'h0, (n - k) >= 7}, 8'h01, "cycle shorter than 35 ns");
    cmp(u_mem.mem[a], d, "stored byte");
    cmp(o_dq_out, d, "data not held");
    cmp(o_addr[7:0], a[7:0], "address not held");
    cmp({7'h0, o_dq_oe}, 8'h00, "lanes still driven");
  endtask : wr
  // request pending through reset and startup must wait
  task automatic t_startup;
    repeat (20) begin
      @(posedge i_clk);
      #1 cmp({5'h0, o_req_ready, o_strobe.cs_n, o_strobe.we_n}, 8'h03, "early access");
    end
    wr(15'h0000, 8'ha5, 1'b0);
  endtask : t_startup
  // both ending modes, back to back, at the top address and at address 1
  task automatic t_modes;
    wr(15'h7fff, 8'h5a, 1'b1);
    wr(15'h0001, 8'h3c, 1'b0);
    wr(15'h0001, 8'hc3, 1'b1);
    cmp(u_mem.mem[15'h7fff], 8'h5a, "neighbour overwritten");
    cmp(u_mem.mem[15'h0000], 8'ha5, "first byte lost");
  endtask : t_modes
  // reset in mid-run: the startup wait must be kept again
  task automatic t_rerun;
    i_rstn = 1'b0;
    @(posedge i_clk);
    #1 i_rstn = 1'b1;
    t_startup();
  endtask : t_rerun
  initial begin
    @(posedge i_clk);
    #1 i_req_valid = 1'b1;
    i_req = '{15'h0000, 8'ha5, 1'b0};
    repeat (19) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    t_startup();
    t_modes();
    t_rerun();
    tally_and_finish();
  end
endmodule : abw_host_test
